// File: verilog/complementary_pwm_adc_trigger.sv
/*
 Three-phase complementary PWM timer with dead time, period toggle output,
 buffered duty compares via hidden stages, interrupt skipping and a delayed
 converter start trigger. Assumes an APB master on pclk and an on-chip
 converter that samples the one-cycle start pulse.
*/
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "cpwm_map.svh"
module complementary_pwm_adc_trigger
    import cpwm_pkg::*;
(
    input wire logic pclk, // Timer clock, 20 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    output logic converter_start_trigger, // Converter start pulse
    output logic period_interrupt, // Period compare interrupt level
    output logic underflow_interrupt, // Underflow interrupt pulse
    output logic period_toggle_output, // Toggle per PWM period
    output logic phase_u_positive, // Phase U high side
    output logic phase_u_negative, // Phase U low side
    output logic phase_v_positive, // Phase V high side
    output logic phase_v_negative, // Phase V low side
    output logic phase_w_positive, // Phase W high side
    output logic phase_w_negative // Phase W low side
);
    state_s s_reg;
    state_s s_next;
    logic err_reg;
    logic err_next;

    function automatic logic [1:0] phase_drive(input word_t cnt_a,
                                               input word_t cnt_b,
                                               input word_t duty,
                                               input word_t dead);
        logic [1:0] r;
        word_t lo;

        r = 2'b00;
        lo = duty - dead;
        // Positive side on when phase A counter exceeds duty
        if (cnt_a > duty) begin
            r[1] = 1'b1;
        end
        // Negative side on when phase B counter is under duty less dead time
        if (cnt_b < lo && duty > dead) begin
            r[0] = 1'b1;
        end

        if (r == 2'b11) begin
            r = 2'b00;
        end
        return r;
    endfunction : phase_drive

    logic wr_en;
    logic rd_en;
    logic mapped;

    logic crest;
    logic trough;
    logic in_mode;
    logic skip_pass;
    logic xfer_ok;
    logic trig_hit;
    logic turn_a_up;
    logic turn_b_down;
    logic up_ok;
    logic down_ok;
    logic link_ok;

    logic [1:0] pu;
    logic [1:0] pv;
    logic [1:0] pw;
    logic [31:0] rdata;

    // ==========================================================
    // Register bus decode
    always_comb begin
        wr_en = psel && penable && pwrite;
        rd_en = psel && !penable && !pwrite;
        mapped = (paddr <= `OFF_STATUS) && (paddr[1:0] == 2'b00);
        rdata = 32'h00000000;

        unique case (paddr)
            `OFF_CONTROL: rdata = {24'h0, s_reg.mode, 2'b00,
                                   s_reg.toggle_en, s_reg.run};
            `OFF_PHASE_A_COUNTER:
                rdata = {16'h0, s_reg.cnt_a};
            `OFF_PHASE_B_COUNTER:
                rdata = {16'h0, s_reg.cnt_b};
            `OFF_HALF_PERIOD_COMPARE: rdata = {16'h0, s_reg.half_period_compare};
            `OFF_FIRST_DUTY_COMPARE:
                rdata = {16'h0, s_reg.first_phase_duty_compare};
            `OFF_HALF_PERIOD_BUFFER:
                rdata = {16'h0, s_reg.half_period_buffer};
            `OFF_FIRST_DUTY_BUFFER:
                rdata = {16'h0, s_reg.first_phase_duty_buffer};
            `OFF_SECOND_DUTY_COMPARE:
                rdata = {16'h0, s_reg.second_phase_duty_compare};
            `OFF_THIRD_DUTY_COMPARE:
                rdata = {16'h0, s_reg.third_phase_duty_compare};
            `OFF_SECOND_DUTY_BUFFER:
                rdata = {16'h0, s_reg.second_phase_duty_buffer};
            `OFF_THIRD_DUTY_BUFFER:
                rdata = {16'h0, s_reg.third_phase_duty_buffer};
            `OFF_DEAD_TIME: rdata = {16'h0, s_reg.dead_time_value};
            `OFF_HALF_CARRIER: rdata = {16'h0, s_reg.half_carrier_cycle};
            `OFF_CARRIER_BUFFER:
                rdata = {16'h0, s_reg.carrier_cycle_buffer};
            `OFF_SKIP: rdata = {25'h0, s_reg.skip_counter, 1'b0,
                                s_reg.skip_setting};
            `OFF_BUFFER_TRANSFER:
                rdata = {30'h0, s_reg.buffer_transfer_setting};
            `OFF_CONV_CONTROL:
                rdata = {16'h0, s_reg.conversion_request_control};
            `OFF_CONV_DELAY:
                rdata = {16'h0, s_reg.conversion_delay_compare};
            `OFF_CONV_DELAY_BUFFER:
                rdata = {16'h0, s_reg.conversion_delay_buffer};
            `OFF_STATUS: rdata = {29'h0, s_reg.dir_b, s_reg.dir_a,
                                  s_reg.period_compare_flag};
            default: rdata = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Counter turning points and event qualifiers
    always_comb begin
        in_mode = s_reg.run && (s_reg.mode == `MODE_COMPLEMENTARY);
        crest = in_mode && s_reg.dir_a == DIR_UP &&
                s_reg.cnt_a == s_reg.half_period_compare;
        trough = in_mode && s_reg.dir_b == DIR_DOWN &&
                 s_reg.cnt_b == 16'h0000;
        skip_pass = (s_reg.skip_setting == 3'h0) ||
                    (s_reg.skip_counter == s_reg.skip_setting);
        xfer_ok = !s_reg.buffer_transfer_setting[`BTE_SUPPRESS_BIT] &&
                  (!s_reg.buffer_transfer_setting[`BTE_LINK_BIT] ||
                   skip_pass);
        turn_a_up = in_mode && s_reg.dir_a == DIR_DOWN &&
                    s_reg.cnt_a == s_reg.dead_time_value;
        turn_b_down = in_mode && s_reg.dir_b == DIR_UP &&
                      s_reg.cnt_b == s_reg.half_carrier_cycle;

        up_ok = s_reg.dir_b == DIR_UP &&
                s_reg.conversion_request_control[`CONV_UP_EN_BIT];
        down_ok = s_reg.dir_b == DIR_DOWN &&
                  s_reg.conversion_request_control[`CONV_DOWN_EN_BIT];
        link_ok = !s_reg.conversion_request_control[`CONV_LINK_BIT] ||
                  skip_pass;
        trig_hit = in_mode && (up_ok || down_ok) && link_ok &&
                   s_reg.cnt_b == s_reg.conversion_delay_compare;
        pu = phase_drive(s_reg.cnt_a, s_reg.cnt_b,
                         s_reg.first_phase_duty_compare,
                         s_reg.dead_time_value);
        pv = phase_drive(s_reg.cnt_a, s_reg.cnt_b,
                         s_reg.second_phase_duty_compare,
                         s_reg.dead_time_value);
        pw = phase_drive(s_reg.cnt_a, s_reg.cnt_b,
                         s_reg.third_phase_duty_compare,
                         s_reg.dead_time_value);
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_next = s_reg;
        err_next = 1'b0;
        s_next.pready = 1'b0;
        s_next.converter_start_trigger = 1'b0;
        s_next.underflow_interrupt = 1'b0;

        // Read data is captured at setup
        if (rd_en) begin
            s_next.prdata = mapped ? rdata : 32'h00000000;
        end
        if (psel && !penable) begin
            s_next.pready = 1'b1;
        end
        // Error flag follows the access by one cycle
        if (psel && penable) begin
            err_next = !mapped;
        end

        // Counters
        if (in_mode) begin
            if (s_reg.dir_a == DIR_UP) begin
                s_next.cnt_a = s_reg.cnt_a + 16'h0001;
            end else begin
                s_next.cnt_a = s_reg.cnt_a - 16'h0001;
            end
            if (crest) begin
                s_next.dir_a = DIR_DOWN;
                s_next.cnt_a = s_reg.cnt_a - 16'h0001;
            end
            if (turn_a_up) begin
                s_next.dir_a = DIR_UP;
                s_next.cnt_a = s_reg.cnt_a + 16'h0001;
            end
            if (s_reg.dir_b == DIR_UP) begin
                s_next.cnt_b = s_reg.cnt_b + 16'h0001;
            end else begin
                s_next.cnt_b = s_reg.cnt_b - 16'h0001;
            end
            if (turn_b_down) begin
                s_next.dir_b = DIR_DOWN;
                s_next.cnt_b = s_reg.cnt_b - 16'h0001;
            end
            if (trough) begin
                s_next.dir_b = DIR_UP;
                s_next.cnt_b = 16'h0001;
            end
        end

        // Skip counting on crest and trough
        if (crest || trough) begin
            if (skip_pass) begin
                s_next.skip_counter = 3'h0;
            end else begin
                s_next.skip_counter = s_reg.skip_counter + 3'h1;
            end
        end

        // Duty buffers enter the hidden stages at the crest
        if (crest) begin
            if (xfer_ok) begin
                s_next.hidden_stage_one = s_reg.first_phase_duty_buffer;
                s_next.hidden_stage_two = s_reg.second_phase_duty_buffer;
                s_next.hidden_stage_three = s_reg.third_phase_duty_buffer;
            end
            if (s_reg.toggle_en) begin
                s_next.period_toggle_output = !s_reg.period_toggle_output;
            end
        end

        if (trough) begin
            // Stages feed compares at the trough
            s_next.first_phase_duty_compare = s_reg.hidden_stage_one;
            s_next.second_phase_duty_compare = s_reg.hidden_stage_two;
            s_next.third_phase_duty_compare = s_reg.hidden_stage_three;
            s_next.half_period_compare = s_reg.half_period_buffer;
            s_next.half_carrier_cycle = s_reg.carrier_cycle_buffer;
            if (s_reg.conversion_request_control[`CONV_TIMING_LSB +: 2] ==
                `CONV_TIMING_TROUGH) begin
                s_next.conversion_delay_compare =
                    s_reg.conversion_delay_buffer;
            end
            if (skip_pass) begin
                s_next.underflow_interrupt = 1'b1;
            end
        end

        s_next.converter_start_trigger = trig_hit;
        s_next.pins = {pu, pv, pw};

        // Register writes
        if (wr_en) begin
            unique case (paddr)
                `OFF_CONTROL: begin
                    s_next.run = pwdata[`CTL_RUN_BIT];
                    s_next.toggle_en = pwdata[`CTL_TOGGLE_EN_BIT];
                    s_next.mode = pwdata[`CTL_MODE_LSB +: 4];
                end
                `OFF_PHASE_A_COUNTER:
                    s_next.cnt_a = pwdata[15:0];
                `OFF_PHASE_B_COUNTER:
                    s_next.cnt_b = pwdata[15:0];
                `OFF_HALF_PERIOD_COMPARE:
                    s_next.half_period_compare = pwdata[15:0];
                `OFF_FIRST_DUTY_COMPARE:
                    s_next.first_phase_duty_compare = pwdata[15:0];
                `OFF_HALF_PERIOD_BUFFER:
                    s_next.half_period_buffer = pwdata[15:0];
                `OFF_FIRST_DUTY_BUFFER:
                    s_next.first_phase_duty_buffer = pwdata[15:0];
                `OFF_SECOND_DUTY_COMPARE:
                    s_next.second_phase_duty_compare = pwdata[15:0];
                `OFF_THIRD_DUTY_COMPARE:
                    s_next.third_phase_duty_compare = pwdata[15:0];
                `OFF_SECOND_DUTY_BUFFER:
                    s_next.second_phase_duty_buffer = pwdata[15:0];
                `OFF_THIRD_DUTY_BUFFER:
                    s_next.third_phase_duty_buffer = pwdata[15:0];
                `OFF_DEAD_TIME:
                    s_next.dead_time_value = pwdata[15:0];
                `OFF_HALF_CARRIER:
                    s_next.half_carrier_cycle = pwdata[15:0];
                `OFF_CARRIER_BUFFER:
                    s_next.carrier_cycle_buffer = pwdata[15:0];
                `OFF_SKIP:
                    s_next.skip_setting = pwdata[`SKIP_SET_LSB +: 3];
                `OFF_BUFFER_TRANSFER:
                    s_next.buffer_transfer_setting = pwdata[1:0];
                `OFF_CONV_CONTROL:
                    s_next.conversion_request_control = pwdata[15:0];
                `OFF_CONV_DELAY:
                    s_next.conversion_delay_compare = pwdata[15:0];
                `OFF_CONV_DELAY_BUFFER:
                    s_next.conversion_delay_buffer = pwdata[15:0];
                `OFF_STATUS: begin
                    if (pwdata[`STAT_FLAG_BIT]) begin
                        s_next.period_compare_flag = 1'b0;
                    end
                end
                default: s_next.run = s_reg.run;
            endcase
        end

        // Set wins over a clear in the same cycle
        if (crest && skip_pass) begin
            s_next.period_compare_flag = 1'b1;
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            err_reg <= 1'b0;
        end else begin
            s_reg <= s_next;
            err_reg <= err_next;
        end
    end

    // ==========================================================
    // Output ports
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = err_reg;
    assign converter_start_trigger = s_reg.converter_start_trigger;
    assign period_interrupt = s_reg.period_compare_flag;
    assign underflow_interrupt = s_reg.underflow_interrupt;
    assign period_toggle_output = s_reg.period_toggle_output;
    assign phase_u_positive = s_reg.pins[5];
    assign phase_u_negative = s_reg.pins[4];
    assign phase_v_positive = s_reg.pins[3];
    assign phase_v_negative = s_reg.pins[2];
    assign phase_w_positive = s_reg.pins[1];
    assign phase_w_negative = s_reg.pins[0];
endmodule : complementary_pwm_adc_trigger

// File: verilog/cpwm_map.svh
/*
 Register offsets, field positions and reset values of the
 complementary PWM timer. Assumes inclusion by bare name.
*/
`ifndef CPWM_MAP_SVH
`define CPWM_MAP_SVH
`define OFF_CONTROL 12'h000
`define OFF_PHASE_A_COUNTER 12'h004
`define OFF_PHASE_B_COUNTER 12'h008
`define OFF_HALF_PERIOD_COMPARE 12'h00C
`define OFF_FIRST_DUTY_COMPARE 12'h010
`define OFF_HALF_PERIOD_BUFFER 12'h014
`define OFF_FIRST_DUTY_BUFFER 12'h018
`define OFF_SECOND_DUTY_COMPARE 12'h01C
`define OFF_THIRD_DUTY_COMPARE 12'h020
`define OFF_SECOND_DUTY_BUFFER 12'h024
`define OFF_THIRD_DUTY_BUFFER 12'h028
`define OFF_DEAD_TIME 12'h02C
`define OFF_HALF_CARRIER 12'h030
`define OFF_CARRIER_BUFFER 12'h034
`define OFF_SKIP 12'h038
`define OFF_BUFFER_TRANSFER 12'h03C
`define OFF_CONV_CONTROL 12'h040
`define OFF_CONV_DELAY 12'h044
`define OFF_CONV_DELAY_BUFFER 12'h048
`define OFF_STATUS 12'h04C
`define CTL_RUN_BIT 0
`define CTL_TOGGLE_EN_BIT 1
`define CTL_MODE_LSB 4
`define MODE_COMPLEMENTARY 4'hF
`define SKIP_SET_LSB 0
`define SKIP_CNT_LSB 4
`define BTE_SUPPRESS_BIT 0
`define BTE_LINK_BIT 1
`define CONV_TIMING_LSB 14
`define CONV_TIMING_TROUGH 2'h2
`define CONV_UP_EN_BIT 7
`define CONV_DOWN_EN_BIT 6
`define CONV_LINK_BIT 0
`define STAT_FLAG_BIT 0
`define STAT_DIR_A_BIT 1
`define STAT_DIR_B_BIT 2
`define RESET_CONV_CONTROL 16'h0000
`endif

// File: verilog/cpwm_pkg.sv
/*
 Types of the complementary PWM timer. Assumes cpwm_map.svh alongside.
*/
package cpwm_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic {DIR_UP, DIR_DOWN} dir_e;
    typedef struct packed {
        logic run;
        logic toggle_en;
        logic [3:0] mode;
        word_t cnt_a;
        word_t cnt_b;
        dir_e dir_a;
        dir_e dir_b;
        word_t half_period_compare;
        word_t first_phase_duty_compare;
        word_t half_period_buffer;
        word_t first_phase_duty_buffer;
        word_t second_phase_duty_compare;
        word_t third_phase_duty_compare;
        word_t second_phase_duty_buffer;
        word_t third_phase_duty_buffer;
        word_t hidden_stage_one;
        word_t hidden_stage_two;
        word_t hidden_stage_three;
        word_t dead_time_value;
        word_t half_carrier_cycle;
        word_t carrier_cycle_buffer;
        logic [2:0] skip_setting;
        logic [2:0] skip_counter;
        logic [1:0] buffer_transfer_setting;
        word_t conversion_request_control;
        word_t conversion_delay_compare;
        word_t conversion_delay_buffer;
        logic period_compare_flag;
        logic underflow_interrupt;
        logic converter_start_trigger;
        logic period_toggle_output;
        logic [5:0] pins;
        logic [31:0] prdata;
        logic pready;
    } state_s;
endpackage : cpwm_pkg

// File: dv/cpwm_assertions.sv
/*
 Port checker of the complementary PWM timer.
 Assumes binding to the timer top module.
*/
`timescale 1ns/1ps
`include "cpwm_map.svh"
module cpwm_assertions (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic converter_start_trigger, // Start pulse
    input wire logic period_interrupt, // Period flag
    input wire logic underflow_interrupt, // Underflow pulse
    input wire logic phase_u_positive, // U high
    input wire logic phase_u_negative, // U low
    input wire logic phase_v_positive, // V high
    input wire logic phase_v_negative, // V low
    input wire logic phase_w_positive, // W high
    input wire logic phase_w_negative // W low
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================
    // Bus phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    // ========================================
    // Properties
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("ready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready too long");
    a_read_data_hold: assert property (
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    a_unmapped_error: assert property (s_access ##0
        (paddr > `OFF_STATUS || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("no error on unmapped access");
    a_mapped_no_error: assert property (s_access ##0
        !(paddr > `OFF_STATUS || paddr[1:0] != 2'h0) |=> !pslverr)
        else $error("error on mapped access");
    a_phase_no_overlap: assert property (
        !(phase_u_positive && phase_u_negative) &&
        !(phase_v_positive && phase_v_negative) &&
        !(phase_w_positive && phase_w_negative))
        else $error("both sides of a phase on");
    a_trigger_one_cycle: assert property (
        converter_start_trigger |=> !converter_start_trigger)
        else $error("start pulse too long");
    a_underflow_pulse: assert property (
        underflow_interrupt |=> !underflow_interrupt)
        else $error("underflow pulse too long");
    a_flag_holds: assert property (period_interrupt && !(psel &&
        penable && pwrite && paddr == `OFF_STATUS && pwdata[0])
        |=> period_interrupt)
        else $error("period flag dropped");
endmodule : cpwm_assertions
bind complementary_pwm_adc_trigger cpwm_assertions i_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .converter_start_trigger(converter_start_trigger),
    .period_interrupt(period_interrupt),
    .underflow_interrupt(underflow_interrupt),
    .phase_u_positive(phase_u_positive), .phase_u_negative(phase_u_negative),
    .phase_v_positive(phase_v_positive), .phase_v_negative(phase_v_negative),
    .phase_w_positive(phase_w_positive), .phase_w_negative(phase_w_negative));

// File: dv/cpwm_far_side.sv
/*
 Converter start input and pin watcher beside the timer.
 Assumes the timer clock and reset.
*/
`timescale 1ns/1ps
module cpwm_far_side (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic converter_start_trigger, // Start request
    input wire logic period_toggle_output, // Toggle pin
    input wire logic phase_u_positive, // U high pin
    output int start_count, // Conversions begun
    output int toggle_count, // Toggle pin changes
    output int edge_count // U high pin changes
);
    logic tgl_q, pos_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_count <= 0;
            toggle_count <= 0;
            edge_count <= 0;
            tgl_q <= 1'b0;
            pos_q <= 1'b0;
        end else begin
            tgl_q <= period_toggle_output;
            pos_q <= phase_u_positive;
            if (converter_start_trigger)
                start_count <= start_count + 1;
            if (tgl_q != period_toggle_output)
                toggle_count <= toggle_count + 1;
            if (pos_q != phase_u_positive)
                edge_count <= edge_count + 1;
        end
    end
endmodule : cpwm_far_side

// File: dv/complementary_pwm_adc_trigger_tb.sv
/*
 Self-checking bench of the complementary PWM timer.
 Assumes the design, package, map header, checker and far-side model.
*/
`timescale 1ns/1ps
`include "cpwm_map.svh"
module complementary_pwm_adc_trigger_tb
    import cpwm_pkg::*;
();
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, trig, per_irq, tgl, err, uf;
    logic [5:0] pin;
    word_t base;
    int fail_count = 0;
    int tests_run = 0;
    int starts, toggles, edges, tbase, ufs, ubase;
    logic [11:0] cfg_a [15] = '{`OFF_DEAD_TIME, `OFF_HALF_CARRIER,
        `OFF_CARRIER_BUFFER, `OFF_HALF_PERIOD_COMPARE,
        `OFF_HALF_PERIOD_BUFFER, `OFF_FIRST_DUTY_COMPARE,
        `OFF_FIRST_DUTY_BUFFER, `OFF_SECOND_DUTY_COMPARE,
        `OFF_SECOND_DUTY_BUFFER, `OFF_THIRD_DUTY_COMPARE,
        `OFF_THIRD_DUTY_BUFFER, `OFF_PHASE_A_COUNTER, `OFF_CONV_DELAY,
        `OFF_CONV_DELAY_BUFFER, `OFF_CONV_CONTROL};
    logic [15:0] cfg_d [15] = '{16'h4, 16'h28, 16'h28, 16'h2C, 16'h2C,
        16'h14, 16'h14, 16'h14, 16'h14, 16'h1E, 16'h1E, 16'h4, 16'h14,
        16'h14, 16'h8080};
    logic [11:0] buf_a [5] = '{`OFF_HALF_PERIOD_BUFFER, `OFF_CARRIER_BUFFER,
        `OFF_FIRST_DUTY_BUFFER, `OFF_SECOND_DUTY_BUFFER,
        `OFF_THIRD_DUTY_BUFFER};
    logic [11:0] cmp_a [5] = '{`OFF_HALF_PERIOD_COMPARE, `OFF_HALF_CARRIER,
        `OFF_FIRST_DUTY_COMPARE, `OFF_SECOND_DUTY_COMPARE,
        `OFF_THIRD_DUTY_COMPARE};
    logic [15:0] buf_d [5] = '{16'h34, 16'h30, 16'h18, 16'h18, 16'h20};
    complementary_pwm_adc_trigger i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .converter_start_trigger(trig),
        .period_interrupt(per_irq), .underflow_interrupt(uf),
        .period_toggle_output(tgl), .phase_u_positive(pin[0]),
        .phase_u_negative(pin[1]), .phase_v_positive(pin[2]),
        .phase_v_negative(pin[3]), .phase_w_positive(pin[4]),
        .phase_w_negative(pin[5]));
    cpwm_far_side i_far (.pclk(pclk), .presetn(presetn),
        .converter_start_trigger(trig), .period_toggle_output(tgl),
        .phase_u_positive(pin[0]), .start_count(starts),
        .toggle_count(toggles), .edge_count(edges));
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        ufs <= ufs + int'(uf === 1'b1);
    end
    // ========================================
    // Tasks
    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic truth(input logic c);
        check({31'h0, c}, 32'h1);
    endtask : truth
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        err = pslverr;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle
    // ========================================
    // Sequence
    initial begin
        idle(20);
        presetn <= 1'b1;
        idle(1);
        for (int i = 0; i < 15; i++) begin
            rd(cfg_a[i], q);
            check(q, 32'h0);
            wr(cfg_a[i], {16'hABCD, cfg_d[i]});
            rd(cfg_a[i], q);
            check(q, {16'h0, cfg_d[i]});
        end
        rd(12'h050, q);
        truth(q === 32'h0 && err === 1'b1);
        wr(12'h02E, 32'hFFFF);
        truth(err === 1'b1);
        rd(`OFF_DEAD_TIME, q);
        check(q, 32'h4);
        wr(`OFF_CONTROL, 32'hF3);
        base = 16'(starts);
        tbase = toggles;
        ubase = ufs;
        idle(800);
        truth(starts - base inside {[9:11]});
        truth(ufs - ubase inside {[9:11]});
        truth(toggles - tbase inside {[9:11]} && edges > 0);
        for (int i = 0; i < 16; i++) begin
            rd(`OFF_PHASE_B_COUNTER, q);
            truth(q <= 32'h28);
            rd(`OFF_PHASE_A_COUNTER, q);
            truth(q >= 32'h4 && q <= 32'h2C);
        end
        wr(`OFF_STATUS, 32'h1);
        for (int n = 0; n < 200 && per_irq !== 1'b1; n++)
            idle(1);
        if (per_irq !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
        wr(`OFF_STATUS, 32'h1);
        truth(per_irq === 1'b0);
        wr(`OFF_CONV_CONTROL, 32'h8000);
        base = 16'(starts);
        idle(400);
        truth(starts == base);
        wr(`OFF_CONV_CONTROL, 32'h8080);
        for (int i = 0; i < 5; i++)
            wr(buf_a[i], {16'h0, buf_d[i]});
        idle(300);
        for (int i = 0; i < 5; i++) begin
            rd(cmp_a[i], q);
            check(q, {16'h0, buf_d[i]});
        end
        wr(`OFF_CONV_DELAY_BUFFER, 32'h32);
        idle(200);
        rd(`OFF_CONV_DELAY, q);
        check(q, 32'h32);
        base = 16'(starts);
        idle(400);
        truth(starts == base);
        wr(`OFF_BUFFER_TRANSFER, 32'h1);
        wr(`OFF_FIRST_DUTY_BUFFER, 32'h10);
        idle(300);
        rd(`OFF_FIRST_DUTY_COMPARE, q);
        check(q, 32'h18);
        wr(`OFF_SKIP, 32'h3);
        for (int i = 0; i < 8; i++) begin
            idle(40);
            rd(`OFF_SKIP, q);
            truth(q[2:0] == 3'h3 && q[6:4] <= 3'h3);
        end
        wr(`OFF_CONTROL, 32'h3);
        wr(`OFF_PHASE_A_COUNTER, 32'h9);
        idle(10);
        rd(`OFF_PHASE_A_COUNTER, q);
        check(q, 32'h9);
        report_and_stop();
    end
endmodule : complementary_pwm_adc_trigger_tb
